// >>> hw/sgcr_regs_map.svh
// Register indices, field positions and reset values of the global configuration registers.
// Notes on behaviour
// - Reserved indices 0x08-0x1F, 0x25, 0x28-0x2A ignore writes and read zero.
// - Identification index 0x20 reads a fixed 8-bit code; writes do nothing.
// - Revision index 0x21 reads a fixed 8-bit code; read-only.
// - Power bits: 0 floppy, 3 parallel, 4 serial one, 5 serial two.
// - A power bit at one enables its function; zero disables it.
// - Auto power management bits 0,3,4,5 enable per function.
// - Auto power management bits 7:6 always read zero.
// - Oscillator bit 1 zero keeps PLL running; one turns it off.
// - Oscillator field 3:2 code 11 stops oscillator and baud clock.
// - Oscillator bit 7 picks alarm interrupt polarity; bits 6:4 read zero.
// - Address low byte holds port bits 7:1; bit 0 fixed zero.
// - Address high byte holds port bits 15:8.
// - Port address is any even 16-bit address.
// - Writing the high byte moves the port at once.
// - Port address resets only on hard reset, not soft reset.
// - Strap low gives default 3F0, strap high gives 370.
// - Host selects index then accesses data, only in configuration mode.
`ifndef SGCR_REGS_MAP_SVH
`define SGCR_REGS_MAP_SVH
`define SGCR_IDX_RSVD_LO    8'h08
`define SGCR_IDX_RSVD_HI    8'h1f
`define SGCR_IDX_ID         8'h20
`define SGCR_IDX_REV        8'h21
`define SGCR_IDX_PWR        8'h22
`define SGCR_IDX_APM        8'h23
`define SGCR_IDX_OSC        8'h24
`define SGCR_IDX_ADDR_LO    8'h26
`define SGCR_IDX_ADDR_HI    8'h27
`define SGCR_IDX_TEST4      8'h2b
`define SGCR_IDX_TEST5      8'h2c
`define SGCR_IDX_TEST1      8'h2d
`define SGCR_IDX_TEST2      8'h2e
`define SGCR_IDX_TEST3      8'h2f
`define SGCR_PWR_MASK       8'h39
`define SGCR_APM_MASK       8'h39
`define SGCR_OSC_MASK       8'h8f
`define SGCR_ADDR_LO_MASK   8'hfe
`define SGCR_TEST_MASK      8'hff
`define SGCR_READ_ZERO      8'h00
`define SGCR_PWR_RESET      8'h00
`define SGCR_APM_RESET      8'h00
`define SGCR_OSC_RESET      8'h04
`define SGCR_TEST_RESET     8'h00
`define SGCR_ADDR_LO_STRAP0 8'hf0
`define SGCR_ADDR_LO_STRAP1 8'h70
`define SGCR_ADDR_HI_RESET  8'h03
`define SGCR_BIT_FLOPPY     0
`define SGCR_BIT_PARALLEL   3
`define SGCR_BIT_SERIAL1    4
`define SGCR_BIT_SERIAL2    5
`define SGCR_BIT_PLL_OFF    1
`define SGCR_OSC_FIELD_HI   3
`define SGCR_OSC_FIELD_LO   2
`define SGCR_OSC_STOP       2'h3
`define SGCR_BIT_ALARM_POL  7
`endif

// >>> hw/sgcr_pkg.sv
// Types shared by the global configuration register block.
package sgcr_pkg;
  typedef logic [7:0] sgcr_byte_t;
endpackage

// >>> hw/sgcr_global_config_regs.sv
// Global configuration register bank reached by index and data strobes.
`timescale 1ns/10ps
`default_nettype none
`include "sgcr_regs_map.svh"

// ==========================================================================
// Byte register
// ==========================================================================
// One writable byte with a synchronous clear. Bits outside the mask are held
// at zero, so reserved positions always read back as zero.
module sgcr_byte_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK  = 8'hff
) (
  input  wire logic       core_clk,
  input  wire logic       clear,
  input  wire logic       load,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] value
);

  // A clear wins over a load in the same cycle, as a reset should.
  always_ff @(posedge core_clk)
  begin
    if (clear)
    begin
      value <= RESET_VALUE;
    end
    else if (load)
    begin
      value <= dataIn & WRITE_MASK;
    end
  end

endmodule // sgcr_byte_reg

module sgcr_global_config_regs #(
  parameter logic [7:0] ID_CODE  = 8'h5a, // Arbitrary identification value.
  parameter logic [7:0] REV_CODE = 8'h01  // Arbitrary revision value.
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              softReset,
  input  wire logic              configMode,
  input  wire logic              strapAltAddr,
  input  wire logic [7:0]        regIndex,
  input  wire logic              dataWrite,
  input  wire logic              dataRead,
  input  wire logic [7:0]        dataIn,
  output logic      [7:0]        dataOut,
  output logic                   floppyControllerPower,
  output logic                   parallelPower,
  output logic                   serial1Power,
  output logic                   serial2Power,
  output logic                   floppyControllerAutoPm,
  output logic                   parallelAutoPm,
  output logic                   serial1AutoPm,
  output logic                   serial2AutoPm,
  output logic                   pllEnable,
  output logic                   oscEnable,
  output logic                   baudClockGeneratorEnable,
  output logic                   clockAlarmInterruptLineActiveLow,
  output logic      [15:0]       configPortAddr
);

  // ==========================================================================
  // Strap capture
  // ==========================================================================
  // The strap passes three flops; a level counts once the last two agree.
  logic       strapMeta;
  logic       strapSync;
  logic       strapStable;
  logic       strapLevel;

  // The strap is a board level so it is caught by clocked logic, never by reset.
  always_ff @(posedge core_clk)
  begin
    strapMeta   <= strapAltAddr;
    strapSync   <= strapMeta;
    strapStable <= strapSync;
    if (strapSync == strapStable)
    begin
      strapLevel <= strapStable;
    end
  end

  // ==========================================================================
  // Decode
  // ==========================================================================
  // Access is honoured only in configuration mode, after the index was set.
  wire logic wrEn      = dataWrite && configMode;
  wire logic wrPwr     = wrEn && (regIndex == `SGCR_IDX_PWR);
  wire logic wrApm     = wrEn && (regIndex == `SGCR_IDX_APM);
  wire logic wrOsc     = wrEn && (regIndex == `SGCR_IDX_OSC);
  wire logic wrAddrLo  = wrEn && (regIndex == `SGCR_IDX_ADDR_LO);
  wire logic wrAddrHi  = wrEn && (regIndex == `SGCR_IDX_ADDR_HI);
  wire logic wrTest4   = wrEn && (regIndex == `SGCR_IDX_TEST4);
  wire logic wrTest5   = wrEn && (regIndex == `SGCR_IDX_TEST5);
  wire logic wrTest1   = wrEn && (regIndex == `SGCR_IDX_TEST1);
  wire logic wrTest2   = wrEn && (regIndex == `SGCR_IDX_TEST2);
  wire logic wrTest3   = wrEn && (regIndex == `SGCR_IDX_TEST3);

  // ==========================================================================
  // Storage
  // ==========================================================================
  sgcr_pkg::sgcr_byte_t powerEnable;
  sgcr_pkg::sgcr_byte_t autoPmEnable;
  sgcr_pkg::sgcr_byte_t oscControl;
  sgcr_pkg::sgcr_byte_t addrLow;
  sgcr_pkg::sgcr_byte_t addrHigh;
  sgcr_pkg::sgcr_byte_t test4;
  sgcr_pkg::sgcr_byte_t test5;
  sgcr_pkg::sgcr_byte_t test1;
  sgcr_pkg::sgcr_byte_t test2;
  sgcr_pkg::sgcr_byte_t test3;
  logic                 addrLoaded;
  logic [15:0]          activeAddr;

  // The soft reset clears the function bytes and one test byte, never the address.
  wire logic softClear = rst || softReset;

  // Function power byte; reserved bits are masked so they read back zero.
  sgcr_byte_reg #(
    .RESET_VALUE (`SGCR_PWR_RESET),
    .WRITE_MASK  (`SGCR_PWR_MASK)
  ) i_powerReg (
    .core_clk (core_clk),
    .clear    (softClear),
    .load     (wrPwr),
    .dataIn   (dataIn),
    .value    (powerEnable)
  );

  // Automatic power management byte; the top two bits always read zero.
  sgcr_byte_reg #(
    .RESET_VALUE (`SGCR_APM_RESET),
    .WRITE_MASK  (`SGCR_APM_MASK)
  ) i_autoPmReg (
    .core_clk (core_clk),
    .clear    (softClear),
    .load     (wrApm),
    .dataIn   (dataIn),
    .value    (autoPmEnable)
  );

  // Oscillator control byte; bits 6:4 are kept at zero.
  sgcr_byte_reg #(
    .RESET_VALUE (`SGCR_OSC_RESET),
    .WRITE_MASK  (`SGCR_OSC_MASK)
  ) i_oscReg (
    .core_clk (core_clk),
    .clear    (softClear),
    .load     (wrOsc),
    .dataIn   (dataIn),
    .value    (oscControl)
  );

  // The one test byte that the soft reset also clears.
  sgcr_byte_reg #(
    .RESET_VALUE (`SGCR_TEST_RESET),
    .WRITE_MASK  (`SGCR_TEST_MASK)
  ) i_test3Reg (
    .core_clk (core_clk),
    .clear    (softClear),
    .load     (wrTest3),
    .dataIn   (dataIn),
    .value    (test3)
  );

  // Test bytes without a documented default simply start at zero.
  sgcr_byte_reg #(
    .RESET_VALUE (`SGCR_TEST_RESET),
    .WRITE_MASK  (`SGCR_TEST_MASK)
  ) i_test4Reg (
    .core_clk (core_clk),
    .clear    (rst),
    .load     (wrTest4),
    .dataIn   (dataIn),
    .value    (test4)
  );

  // Hard reset only; a soft reset leaves this test byte alone.
  sgcr_byte_reg #(
    .RESET_VALUE (`SGCR_TEST_RESET),
    .WRITE_MASK  (`SGCR_TEST_MASK)
  ) i_test5Reg (
    .core_clk (core_clk),
    .clear    (rst),
    .load     (wrTest5),
    .dataIn   (dataIn),
    .value    (test5)
  );

  // Hard reset only; a soft reset leaves this test byte alone.
  sgcr_byte_reg #(
    .RESET_VALUE (`SGCR_TEST_RESET),
    .WRITE_MASK  (`SGCR_TEST_MASK)
  ) i_test1Reg (
    .core_clk (core_clk),
    .clear    (rst),
    .load     (wrTest1),
    .dataIn   (dataIn),
    .value    (test1)
  );

  // Hard reset only; a soft reset leaves this test byte alone.
  sgcr_byte_reg #(
    .RESET_VALUE (`SGCR_TEST_RESET),
    .WRITE_MASK  (`SGCR_TEST_MASK)
  ) i_test2Reg (
    .core_clk (core_clk),
    .clear    (rst),
    .load     (wrTest2),
    .dataIn   (dataIn),
    .value    (test2)
  );

  // ==========================================================================
  // Configuration port address
  // ==========================================================================
  // Soft reset is deliberately absent: only the hard reset restores it. The
  // default waits one cycle past reset so the strap level is settled.
  wire logic [7:0] strapLow = strapLevel ? `SGCR_ADDR_LO_STRAP1 : `SGCR_ADDR_LO_STRAP0;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      addrLoaded <= 1'b0;
      addrLow    <= `SGCR_ADDR_LO_STRAP0;
      addrHigh   <= `SGCR_ADDR_HI_RESET;
      activeAddr <= {`SGCR_ADDR_HI_RESET, `SGCR_ADDR_LO_STRAP0};
    end
    else if (!addrLoaded)
    begin
      addrLoaded <= 1'b1;
      addrLow    <= strapLow;
      activeAddr <= {addrHigh, strapLow};
    end
    else
    begin
      // Bit 0 is forced low so the port stays on an even address.
      if (wrAddrLo) addrLow <= dataIn & `SGCR_ADDR_LO_MASK;
      if (wrAddrHi)
      begin
        addrHigh   <= dataIn;
        activeAddr <= {dataIn, addrLow};
      end
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  // Unmatched indices, reserved ones included, fall to zero.
  sgcr_pkg::sgcr_byte_t readMux;

  always_comb
  begin
    case (regIndex)
      `SGCR_IDX_ID:      readMux = ID_CODE;
      `SGCR_IDX_REV:     readMux = REV_CODE;
      `SGCR_IDX_PWR:     readMux = powerEnable;
      `SGCR_IDX_APM:     readMux = autoPmEnable;
      `SGCR_IDX_OSC:     readMux = oscControl;
      `SGCR_IDX_ADDR_LO: readMux = addrLow;
      `SGCR_IDX_ADDR_HI: readMux = addrHigh;
      `SGCR_IDX_TEST4:   readMux = test4;
      `SGCR_IDX_TEST5:   readMux = test5;
      `SGCR_IDX_TEST1:   readMux = test1;
      `SGCR_IDX_TEST2:   readMux = test2;
      `SGCR_IDX_TEST3:   readMux = test3;
      default:           readMux = `SGCR_READ_ZERO;
    endcase
  end

  // Read data is registered; it holds until the next read strobe.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dataOut <= `SGCR_READ_ZERO;
    end
    else if (dataRead)
    begin
      dataOut <= configMode ? readMux : `SGCR_READ_ZERO;
    end
  end

  // ==========================================================================
  // Function controls
  // ==========================================================================
  // Controls are straight from register bits, so they follow one cycle after a write.
  assign floppyControllerPower  = powerEnable[`SGCR_BIT_FLOPPY];
  assign parallelPower          = powerEnable[`SGCR_BIT_PARALLEL];
  assign serial1Power           = powerEnable[`SGCR_BIT_SERIAL1];
  assign serial2Power           = powerEnable[`SGCR_BIT_SERIAL2];
  assign floppyControllerAutoPm = autoPmEnable[`SGCR_BIT_FLOPPY];
  assign parallelAutoPm         = autoPmEnable[`SGCR_BIT_PARALLEL];
  assign serial1AutoPm          = autoPmEnable[`SGCR_BIT_SERIAL1];
  assign serial2AutoPm          = autoPmEnable[`SGCR_BIT_SERIAL2];
  assign pllEnable              = !oscControl[`SGCR_BIT_PLL_OFF];

  wire logic oscStopped =
    (oscControl[`SGCR_OSC_FIELD_HI:`SGCR_OSC_FIELD_LO] == `SGCR_OSC_STOP);
  assign oscEnable                        = !oscStopped;
  assign baudClockGeneratorEnable         = !oscStopped;
  assign clockAlarmInterruptLineActiveLow = oscControl[`SGCR_BIT_ALARM_POL];
  assign configPortAddr                   = activeAddr;

endmodule // sgcr_global_config_regs
`default_nettype wire

// >>> test/sgcr_regs_props.sv
// Concurrent checks on the ports of the global configuration register bank.
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Checker module
module sgcr_regs_props #(
  parameter logic [7:0] ID_CODE = 8'h5a // Arbitrary identification value.
) (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        softReset,
  input wire logic        configMode,
  input wire logic [7:0]  regIndex,
  input wire logic        dataWrite,
  input wire logic        dataRead,
  input wire logic [7:0]  dataIn,
  input wire logic [7:0]  dataOut,
  input wire logic        floppyControllerPower,
  input wire logic        serial2Power,
  input wire logic        serial1AutoPm,
  input wire logic        pllEnable,
  input wire logic        oscEnable,
  input wire logic        baudClockGeneratorEnable,
  input wire logic        clockAlarmInterruptLineActiveLow,
  input wire logic [15:0] configPortAddr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Accepted accesses; a soft reset at the same edge is left out as its clear wins over the write.
  wire wr = dataWrite && configMode && !softReset;
  wire rd = dataRead && configMode;
  sequence wrAt(logic [7:0] i);
    wr && regIndex == i;
  endsequence
  pwr_map_a: assert property (wrAt(8'h22) |=>
    floppyControllerPower == $past(dataIn[0]) && serial2Power == $past(dataIn[5]))
    else $error("Power enable does not follow the written byte.");
  apm_map_a: assert property (wrAt(8'h23) |=> serial1AutoPm == $past(dataIn[4]))
    else $error("Auto power enable does not follow the written byte.");
  osc_map_a: assert property (wrAt(8'h24) |=> pllEnable == !$past(dataIn[1])
    && oscEnable == ($past(dataIn[3:2]) != 2'b11)
    && baudClockGeneratorEnable == ($past(dataIn[3:2]) != 2'b11)
    && clockAlarmInterruptLineActiveLow == $past(dataIn[7]))
    else $error("Clock control outputs do not follow the written byte.");
  id_read_a: assert property (rd && regIndex == 8'h20 |=> dataOut == ID_CODE)
    else $error("Identification read wrong.");
  rsvd_read_a: assert property (rd && regIndex inside {[8'h08:8'h1f], 8'h25, [8'h28:8'h2a]} |=>
    dataOut == 8'h00) else $error("Reserved index read nonzero.");
  apm_top_a: assert property (rd && regIndex == 8'h23 |=> dataOut[7:6] == 2'b00)
    else $error("Auto power reserved bits read nonzero.");
  addr_even_a: assert property (configPortAddr[0] == 1'b0)
    else $error("Port address is odd.");
  addr_load_a: assert property (wrAt(8'h27) |=> configPortAddr[15:8] == $past(dataIn))
    else $error("High byte write did not move the port.");
  lo_stage_a: assert property (wrAt(8'h26) |=> $stable(configPortAddr))
    else $error("Low byte write moved the port.");
  addr_keep_a: assert property ($changed(configPortAddr) |->
    $past(dataWrite && configMode && regIndex == 8'h27) || $past(rst) || $past(rst, 2))
    else $error("Port address moved without a high byte write.");
endmodule // sgcr_regs_props
bind sgcr_global_config_regs sgcr_regs_props #(.ID_CODE(ID_CODE)) i_props (.*);
`default_nettype wire

// >>> test/tb_sgcr_global_config_regs.sv
// Randomised self-checking bench for the global configuration register bank.
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Bench top
module tb_sgcr_global_config_regs;
  logic        core_clk, rst, softReset, configMode, strapAltAddr, dataWrite, dataRead;
  logic [7:0]  regIndex, dataIn, dataOut, pw, ap, i, m [256];
  logic [3:0]  os;
  logic [15:0] configPortAddr, act;
  logic [31:0] seed = 32'h4dbcdd07;
  int          num_errors = 0;
  int          checks = 0;
  sgcr_global_config_regs i_dut (.core_clk(core_clk), .rst(rst), .softReset(softReset),
    .configMode(configMode), .strapAltAddr(strapAltAddr), .regIndex(regIndex),
    .dataWrite(dataWrite), .dataRead(dataRead), .dataIn(dataIn), .dataOut(dataOut),
    .floppyControllerPower(pw[0]), .parallelPower(pw[3]), .serial1Power(pw[4]),
    .serial2Power(pw[5]), .floppyControllerAutoPm(ap[0]), .parallelAutoPm(ap[3]),
    .serial1AutoPm(ap[4]), .serial2AutoPm(ap[5]), .pllEnable(os[0]), .oscEnable(os[1]),
    .baudClockGeneratorEnable(os[2]), .clockAlarmInterruptLineActiveLow(os[3]),
    .configPortAddr(configPortAddr));
  // Reserved control positions have no output; tie them so the masked compares read no unknowns.
  assign {pw[7:6], pw[2:1]} = 4'h0;
  assign {ap[7:6], ap[2:1]} = 4'h0;
  // Clock of 8 ns.
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Writable bits per index; zero means the index keeps its value.
  function automatic logic [7:0] msk(input logic [7:0] x);
    case (x)
      8'h22, 8'h23: return 8'h39;
      8'h24: return 8'h8f;
      8'h26: return 8'hfe;
      8'h27, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction
  // Expected {alarm polarity, baud clock, oscillator, pll} for an oscillator byte.
  function automatic logic [3:0] clkExp(input logic [7:0] r);
    return {r[7], {2{r[3:2] != 2'b11}}, !r[1]};
  endfunction
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // One access; the model is updated once the edge that takes it has landed.
  task automatic acc(input logic w, input logic [7:0] x, input logic [7:0] d);
    @(posedge core_clk);
    regIndex <= x;
    dataIn <= d;
    dataWrite <= w;
    dataRead <= !w;
    @(posedge core_clk);
    dataWrite <= 1'b0;
    dataRead <= 1'b0;
    #1;
    if (w && configMode && msk(x) != 8'h00) m[x] = d & msk(x);
    if (w && configMode && x == 8'h27) act = {m[8'h27], m[8'h26]};
    if (!w) chk("readback", {8'h00, dataOut}, {8'h00, configMode ? m[x] : 8'h00});
  endtask
  task automatic wrChk(input logic [7:0] x, input logic [7:0] d);
    acc(1'b1, x, d);
    chk("power", {8'h00, pw & 8'h39}, {8'h00, m[8'h22] & 8'h39});
    chk("autopm", {8'h00, ap & 8'h39}, {8'h00, m[8'h23] & 8'h39});
    chk("clocks", {12'h000, os}, {12'h000, clkExp(m[8'h24])});
    chk("port", configPortAddr, act);
  endtask
  task automatic hardReset(input logic s);
    strapAltAddr <= s;
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    foreach (m[k]) m[k] = 8'h00;
    m[8'h20] = 8'h5a;
    m[8'h21] = 8'h01;
    m[8'h24] = 8'h04;
    m[8'h26] = s ? 8'h70 : 8'hf0;
    m[8'h27] = 8'h03;
    act = {8'h03, m[8'h26]};
    repeat (2) @(posedge core_clk);
    chk("default port", configPortAddr, act);
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the sequence needs.
  initial
  begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
  // Main sequence: reset values, random traffic, relocation, soft and strapped resets.
  initial
  begin
    {rst, softReset, strapAltAddr, dataWrite, dataRead, regIndex, dataIn} <= '0;
    configMode <= 1'b1;
    hardReset(1'b0);
    for (int k = 8; k < 48; k++) acc(1'b0, k[7:0], 8'h00);
    repeat (60)
    begin
      @(posedge core_clk) configMode <= rnd() % 8 != 0;
      i = 8'h08 + 8'(rnd() % 32'd40);
      if (i inside {[8'h2b:8'h2f]}) i = 8'h27; // Host keeps off the vendor test bytes
      if (i == 8'h27) wrChk(8'h26, 8'(rnd())); // Low byte goes first
      wrChk(i, 8'(rnd()));
      acc(1'b0, i, 8'h00);
    end
    @(posedge core_clk) configMode <= 1'b1;
    for (int c = 0; c < 4; c++) wrChk(8'h24, {4'h8, c[1:0], 2'b10});
    wrChk(8'h26, 8'h11);
    wrChk(8'h27, 8'h05);
    @(posedge core_clk) softReset <= 1'b1;
    @(posedge core_clk) softReset <= 1'b0;
    m[8'h22] = 8'h00;
    m[8'h23] = 8'h00;
    m[8'h24] = 8'h04;
    m[8'h2f] = 8'h00;
    wrChk(8'h25, 8'hff);
    @(posedge core_clk);
    hardReset(1'b1);
    acc(1'b0, 8'h26, 8'h00);
    tally_and_finish();
  end
endmodule // tb_sgcr_global_config_regs
`default_nettype wire
